/* pkg/rmstat_pkg.sv */
/*
  Shared constants for the per-port frame statistics block: counter indices,
  frame length class bounds, register offsets and bit positions, engine states.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package rmstat_pkg;

    // Counter storage
    localparam int CNT_W = 32;
    localparam int NCNT  = 17;
    localparam int CIW   = 5;

    // Counter index inside one port's set
    localparam logic [CIW-1:0] C_DROP   = 5'h00;
    localparam logic [CIW-1:0] C_COLL   = 5'h01;
    localparam logic [CIW-1:0] C_BCAST  = 5'h02;
    localparam logic [CIW-1:0] C_MCAST  = 5'h03;
    localparam logic [CIW-1:0] C_CRC    = 5'h04;
    localparam logic [CIW-1:0] C_UNDER  = 5'h05;
    localparam logic [CIW-1:0] C_OVER   = 5'h06;
    localparam logic [CIW-1:0] C_FRAG   = 5'h07;
    localparam logic [CIW-1:0] C_JAB    = 5'h08;
    localparam logic [CIW-1:0] C_PKTS   = 5'h09;
    localparam logic [CIW-1:0] C_OCTETS = 5'h0A;
    localparam logic [CIW-1:0] C_B64    = 5'h0B;
    localparam logic [CIW-1:0] C_B127   = 5'h0C;
    localparam logic [CIW-1:0] C_B255   = 5'h0D;
    localparam logic [CIW-1:0] C_B511   = 5'h0E;
    localparam logic [CIW-1:0] C_B1023  = 5'h0F;
    localparam logic [CIW-1:0] C_B1518  = 5'h10;
    localparam logic [CIW-1:0] C_LAST   = 5'h10;

    // Frame length, counted with check sequence, without preamble
    localparam int              LEN_W   = 16;
    localparam logic [LEN_W-1:0] LEN_MIN = 16'h0040;
    localparam logic [LEN_W-1:0] LEN_127 = 16'h007F;
    localparam logic [LEN_W-1:0] LEN_255 = 16'h00FF;
    localparam logic [LEN_W-1:0] LEN_511 = 16'h01FF;
    localparam logic [LEN_W-1:0] LEN_1K  = 16'h03FF;
    localparam logic [LEN_W-1:0] LEN_MAX = 16'h05EE;

    // Register byte offsets
    localparam int          PAW          = 12;
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_SEL      = 12'h004;
    localparam logic [11:0] REG_SRC      = 12'h008;
    localparam logic [11:0] REG_STAT     = 12'h00C;
    localparam logic [11:0] REG_IRQ_ST   = 12'h010;
    localparam logic [11:0] REG_IRQ_CLR  = 12'h014;
    localparam logic [11:0] REG_IRQ_EN   = 12'h018;
    localparam logic [11:0] REG_CNT_BASE = 12'h100;
    localparam logic [11:0] REG_CNT_END  = 12'h144;

    // Register bit positions
    localparam int CTRL_CLEAR  = 0;
    localparam int CTRL_INIT   = 1;
    localparam int SEL_UP      = 0;
    localparam int SEL_DOWN    = 1;
    localparam int SEL_COMMIT  = 2;
    localparam int STAT_VALID  = 0;
    localparam int NIRQ        = 3;
    localparam int IRQ_CLRDONE = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_INITDONE = 2;

    typedef enum logic [3:0] {
        S_INIT = 4'b0001,
        S_IDLE = 4'b0010,
        S_UPD  = 4'b0100,
        S_CLR  = 4'b1000
    } rmstat_state_t;

endpackage

`default_nettype wire

/* rtl/rmstat_mem.sv */
/*
  Single-port counter store with registered read data, read-before-write.
  Assumes the owner sweeps it to zero after reset; contents have no reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rmstat_mem #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock
    input  wire logic          clk,
    // Access port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

`default_nettype wire

/* rtl/rmstat_top.sv */
/*
  Per-port frame statistics engine with APB register access. Frame, collision
  and drop reports update 32-bit counters held in a small memory by
  read-modify-write; software selects a port, commits it, reads and clears it.
  Assumes report inputs come from logic on clk; port_oper_valid may be async.
*/
`timescale 1ns/1ps
`default_nettype none

module rmstat_top
    import rmstat_pkg::*;
#(
    parameter int NPORT  = 8,
    parameter int PW     = (NPORT > 1) ? $clog2(NPORT) : 1,
    parameter int PEND_W = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [PAW-1:0]   paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Received frame report
    input  wire logic             frm_valid,
    input  wire logic [PW-1:0]    frm_port,
    input  wire logic [LEN_W-1:0] frm_len,
    input  wire logic             frm_crc_ok,
    input  wire logic             frm_bcast,
    input  wire logic             frm_mcast,
    // Collision and resource drop events
    input  wire logic             coll_valid,
    input  wire logic [PW-1:0]    coll_port,
    input  wire logic             drop_valid,
    input  wire logic [PW-1:0]    drop_port,
    // Port operating status
    input  wire logic [NPORT-1:0] port_oper_valid,
    // Interrupt
    output logic                  irq
);

    localparam int AW = PW + CIW;
    localparam logic [PEND_W-1:0] PEND_MAX = '1;

    rmstat_state_t    state_reg;
    logic [AW-1:0]    sweep_reg;
    logic             clr_pend_reg;
    logic [PW-1:0]    clr_port_reg;
    logic [NCNT-1:0]  frm_mask_reg;
    logic [PW-1:0]    frm_port_reg;
    logic [LEN_W-1:0] frm_len_reg;
    logic [PEND_W-1:0] coll_pend_reg [NPORT];
    logic [PEND_W-1:0] drop_pend_reg [NPORT];
    logic [PW-1:0]    stage_idx_reg;
    logic [PW-1:0]    commit_idx_reg;
    logic [AW-1:0]    job_addr_reg;
    logic [CNT_W-1:0] job_inc_reg;
    logic             job_apb_reg;
    logic             apb_wait_reg;
    logic             apb_issued_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic [NIRQ-1:0]  irq_st_reg;
    logic [NIRQ-1:0]  irq_en_reg;
    logic             irq_reg;
    logic [NPORT-1:0] opv_s1_reg;
    logic [NPORT-1:0] opv_s2_reg;

    logic [CNT_W-1:0] mem_rdata;

    // State decode
    wire st_init = (state_reg == S_INIT);
    wire st_idle = (state_reg == S_IDLE);
    wire st_upd  = (state_reg == S_UPD);
    wire st_clr  = (state_reg == S_CLR);
    wire init_end = st_init && (sweep_reg == {AW{1'b1}});
    wire clr_end  = st_clr && (sweep_reg[CIW-1:0] == C_LAST);

    // APB decode
    wire apb_acc   = psel && penable && !pready_reg;
    wire wr_fire   = psel && penable && pwrite && pready_reg;
    wire hit_ctrl  = (paddr == REG_CTRL);
    wire hit_sel   = (paddr == REG_SEL);
    wire hit_src   = (paddr == REG_SRC);
    wire hit_stat  = (paddr == REG_STAT);
    wire hit_irqst = (paddr == REG_IRQ_ST);
    wire hit_irqcl = (paddr == REG_IRQ_CLR);
    wire hit_irqen = (paddr == REG_IRQ_EN);
    wire hit_cnt   = (paddr >= REG_CNT_BASE) && (paddr < REG_CNT_END) && (paddr[1:0] == 2'h0);
    wire mapped    = hit_ctrl || hit_sel || hit_src || hit_stat || hit_irqst || hit_irqcl || hit_irqen || hit_cnt;
    wire cnt_rd    = hit_cnt && !pwrite;
    wire bad_acc   = !mapped || (hit_cnt && pwrite);
    wire [CIW-1:0] cnt_idx = paddr[CIW+1:2];

    // Software commands
    wire clr_cmd   = wr_fire && hit_ctrl && pwdata[CTRL_CLEAR] && !clr_pend_reg;
    wire step_up   = wr_fire && hit_sel && pwdata[SEL_UP];
    wire step_dn   = wr_fire && hit_sel && pwdata[SEL_DOWN];
    wire commit    = wr_fire && hit_sel && pwdata[SEL_COMMIT];
    wire [PW-1:0] top_idx = PW'(NPORT - 1);

    // Frame classification; length already includes FCS
    wire f_good  = frm_crc_ok;
    wire f_short = (frm_len < LEN_MIN);
    wire f_long  = (frm_len > LEN_MAX);
    logic [NCNT-1:0] frm_cls;
    assign frm_cls[C_DROP]   = 1'b0;
    assign frm_cls[C_COLL]   = 1'b0;
    assign frm_cls[C_PKTS]   = 1'b1;
    assign frm_cls[C_OCTETS] = 1'b1;
    assign frm_cls[C_BCAST]  = f_good && frm_bcast;
    assign frm_cls[C_MCAST]  = f_good && frm_mcast && !frm_bcast;
    assign frm_cls[C_CRC]    = !f_good;
    assign frm_cls[C_UNDER]  = f_short && f_good;
    assign frm_cls[C_OVER]   = f_long && f_good;
    assign frm_cls[C_FRAG]   = f_short && !f_good;
    assign frm_cls[C_JAB]    = f_long && !f_good;
    assign frm_cls[C_B64]    = (frm_len == LEN_MIN);
    assign frm_cls[C_B127]   = (frm_len > LEN_MIN) && (frm_len <= LEN_127);
    assign frm_cls[C_B255]   = (frm_len > LEN_127) && (frm_len <= LEN_255);
    assign frm_cls[C_B511]   = (frm_len > LEN_255) && (frm_len <= LEN_511);
    assign frm_cls[C_B1023]  = (frm_len > LEN_511) && (frm_len <= LEN_1K);
    assign frm_cls[C_B1518]  = (frm_len > LEN_1K) && (frm_len <= LEN_MAX);

    // Lowest pending work items
    logic [CIW-1:0] f_low;
    logic [PW-1:0]  c_low;
    logic [PW-1:0]  d_low;
    logic [NPORT-1:0] c_nz;
    logic [NPORT-1:0] d_nz;
    always_comb begin
        f_low = '0;
        for (int i = NCNT - 1; i >= 0; i--) begin
            if (frm_mask_reg[i]) begin
                f_low = CIW'(i);
            end
        end
    end
    always_comb begin
        c_low = '0;
        d_low = '0;
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (c_nz[p]) begin
                c_low = PW'(p);
            end
            if (d_nz[p]) begin
                d_low = PW'(p);
            end
        end
    end

    // Job arbitration: clear, frame, collision, drop, software read
    wire frm_any = |frm_mask_reg;
    wire c_any   = |c_nz;
    wire d_any   = |d_nz;
    wire go_clr  = st_idle && clr_pend_reg;
    wire go_frm  = st_idle && !clr_pend_reg && frm_any;
    wire go_col  = st_idle && !clr_pend_reg && !frm_any && c_any;
    wire go_drp  = st_idle && !clr_pend_reg && !frm_any && !c_any && d_any;
    wire go_apb  = st_idle && !clr_pend_reg && !frm_any && !c_any && !d_any && apb_wait_reg && !apb_issued_reg;
    wire go_job  = go_frm || go_col || go_drp || go_apb;

    wire [AW-1:0] sel_addr = go_frm ? {frm_port_reg, f_low} :
                             go_col ? {c_low, C_COLL} :
                             go_drp ? {d_low, C_DROP} :
                                      {commit_idx_reg, cnt_idx};
    wire [CNT_W-1:0] sel_inc = (go_frm && f_low == C_OCTETS) ? CNT_W'(frm_len_reg) : CNT_W'(1);

    // Counter memory port; sum wraps at 32 bits
    wire             mem_we    = (st_upd && !job_apb_reg) || st_clr || st_init;
    wire [AW-1:0]    mem_addr  = st_idle ? sel_addr : (st_upd ? job_addr_reg : sweep_reg);
    wire [CNT_W-1:0] mem_wdata = st_upd ? (mem_rdata + job_inc_reg) : '0;

    rmstat_mem #(
        .AW (AW),
        .DW (CNT_W)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    // Engine state machine
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg    <= S_INIT;
            sweep_reg    <= '0;
            job_addr_reg <= '0;
            job_inc_reg  <= '0;
            job_apb_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                S_INIT: begin
                    sweep_reg <= sweep_reg + AW'(1);
                    if (init_end) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (go_clr) begin
                        state_reg <= S_CLR;
                        sweep_reg <= {clr_port_reg, {CIW{1'b0}}};
                    end else if (go_job) begin
                        state_reg    <= S_UPD;
                        job_addr_reg <= sel_addr;
                        job_inc_reg  <= sel_inc;
                        job_apb_reg  <= go_apb;
                    end
                end
                S_UPD: begin
                    state_reg <= S_IDLE;
                end
                S_CLR: begin
                    sweep_reg <= sweep_reg + AW'(1);
                    if (clr_end) begin
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Clear request; events for the cleared port this cycle are dropped
    wire clr_hits_frm = clr_cmd && (frm_port_reg == commit_idx_reg);
    wire clr_hits_new = clr_cmd && (frm_port == commit_idx_reg);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clr_pend_reg <= 1'b0;
            clr_port_reg <= '0;
        end else if (clr_cmd) begin
            clr_pend_reg <= 1'b1;
            clr_port_reg <= commit_idx_reg;
        end else if (go_clr) begin
            clr_pend_reg <= 1'b0;
        end
    end

    // Pending frame: one counter served per update cycle
    wire [NCNT-1:0] mask_served = go_frm ? (frm_mask_reg & ~(NCNT'(1) << f_low)) : frm_mask_reg;
    wire [NCNT-1:0] mask_kept   = clr_hits_frm ? '0 : mask_served;
    wire            frm_take    = frm_valid && !clr_hits_new;
    wire            frm_load    = frm_take && (mask_kept == '0);
    wire            ev_overrun  = frm_take && (mask_kept != '0);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frm_mask_reg <= '0;
            frm_port_reg <= '0;
            frm_len_reg  <= '0;
        end else if (frm_load) begin
            frm_mask_reg <= frm_cls;
            frm_port_reg <= frm_port;
            frm_len_reg  <= frm_len;
        end else begin
            frm_mask_reg <= mask_kept;
        end
    end

    // Per-port pending collision and drop-occasion counts
    for (genvar p = 0; p < NPORT; p++) begin : g_pend
        wire wipe  = clr_cmd && (commit_idx_reg == PW'(p));
        wire c_inc = coll_valid && (coll_port == PW'(p));
        wire c_dec = go_col && (c_low == PW'(p));
        wire d_inc = drop_valid && (drop_port == PW'(p));
        wire d_dec = go_drp && (d_low == PW'(p));
        assign c_nz[p] = (coll_pend_reg[p] != '0);
        assign d_nz[p] = (drop_pend_reg[p] != '0);
        always_ff @(posedge clk) begin
            if (!resetn || wipe) begin
                coll_pend_reg[p] <= '0;
                drop_pend_reg[p] <= '0;
            end else begin
                if (c_inc && !c_dec && coll_pend_reg[p] != PEND_MAX) begin
                    coll_pend_reg[p] <= coll_pend_reg[p] + PEND_W'(1);
                end else if (c_dec && !c_inc) begin
                    coll_pend_reg[p] <= coll_pend_reg[p] - PEND_W'(1);
                end
                if (d_inc && !d_dec && drop_pend_reg[p] != PEND_MAX) begin
                    drop_pend_reg[p] <= drop_pend_reg[p] + PEND_W'(1);
                end else if (d_dec && !d_inc) begin
                    drop_pend_reg[p] <= drop_pend_reg[p] - PEND_W'(1);
                end
            end
        end
    end

    // Index staging and commit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage_idx_reg  <= '0;
            commit_idx_reg <= '0;
        end else begin
            if (step_up) begin
                stage_idx_reg <= (stage_idx_reg == top_idx) ? '0 : stage_idx_reg + PW'(1);
            end else if (step_dn) begin
                stage_idx_reg <= (stage_idx_reg == '0) ? top_idx : stage_idx_reg - PW'(1);
            end
            if (commit) begin
                commit_idx_reg <= stage_idx_reg;
            end
        end
    end

    // Status pin synchroniser
    always_ff @(posedge clk) begin
        if (!resetn) begin
            opv_s1_reg <= '0;
            opv_s2_reg <= '0;
        end else begin
            opv_s1_reg <= port_oper_valid;
            opv_s2_reg <= opv_s1_reg;
        end
    end

    // Register read mux
    wire [31:0] src_tag   = 32'(commit_idx_reg) + 32'h0000_0001;         // interface_source_tag
    wire [31:0] reg_rdata = hit_ctrl  ? {30'h0, st_init, clr_pend_reg || st_clr} :
                            hit_sel   ? 32'(stage_idx_reg) :
                            hit_src   ? src_tag :
                            hit_stat  ? {31'h0, opv_s2_reg[commit_idx_reg]} :
                            hit_irqst ? 32'(irq_st_reg) :
                            hit_irqen ? 32'(irq_en_reg) :
                                        32'h0000_0000;

    // APB answer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata_reg     <= '0;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
            apb_wait_reg   <= 1'b0;
            apb_issued_reg <= 1'b0;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            if (apb_acc && !cnt_rd) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= bad_acc;
                prdata_reg  <= bad_acc ? 32'h0000_0000 : reg_rdata;
            end
            if (apb_acc && cnt_rd && !apb_wait_reg) begin
                apb_wait_reg <= 1'b1;
            end
            if (go_apb) begin
                apb_issued_reg <= 1'b1;
            end
            if (st_upd && job_apb_reg) begin
                pready_reg     <= 1'b1;
                prdata_reg     <= mem_rdata;
                apb_wait_reg   <= 1'b0;
                apb_issued_reg <= 1'b0;
            end
        end
    end

    // Interrupt status, set wins over clear
    wire [NIRQ-1:0] irq_ev  = {init_end, ev_overrun, clr_end};
    wire [NIRQ-1:0] irq_clr = (wr_fire && hit_irqcl) ? pwdata[NIRQ-1:0] : '0;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_st_reg <= '0;
            irq_en_reg <= '0;
            irq_reg    <= 1'b0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
            if (wr_fire && hit_irqen) begin
                irq_en_reg <= pwdata[NIRQ-1:0];
            end
            irq_reg <= |(irq_st_reg & irq_en_reg);
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

endmodule

`default_nettype wire

/* sim/rmstat_checker.sv */
/* Port checker for rmstat_top: APB answer timing and refusals.
   Bound to every rmstat_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module rmstat_checker
    import rmstat_pkg::*;
#(
    parameter int NPORT = 8
) (
    // Clock and reset
    input wire logic           clk,
    input wire logic           resetn,
    // APB
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [PAW-1:0] paddr,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Interrupt
    input wire logic           irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic acc1 = psel && penable && !pready;
    property p_rst; disable iff (1'b0) !resetn |=> !pready && !pslverr && !irq && prdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_held; pready |-> psel && penable; endproperty
    a_held: assert property (p_held) else $error("answer without access");
    property p_fast; acc1 && !$past(penable) && paddr < REG_CNT_BASE |=> pready; endproperty
    a_fast: assert property (p_fast) else $error("register answer late");
    property p_slow; acc1 && !$past(penable) && !pwrite && paddr >= REG_CNT_BASE && paddr < REG_CNT_END
        |-> !pready [*3] ##[1:700] pready; endproperty
    a_slow: assert property (p_slow) else $error("counter answer timing");
    property p_cwr; pready && pwrite && paddr >= REG_CNT_BASE && paddr < REG_CNT_END |-> pslverr; endproperty
    a_cwr: assert property (p_cwr) else $error("counter write taken");
    property p_src; pready && !pwrite && paddr == REG_SRC |-> prdata >= 32'h1 && prdata <= NPORT; endproperty
    a_src: assert property (p_src) else $error("source tag out of range");
    property p_stat; pready && !pwrite && paddr == REG_STAT |-> prdata[31:1] == '0; endproperty
    a_stat: assert property (p_stat) else $error("status spare bits set");
endmodule
bind rmstat_top rmstat_checker #(.NPORT(NPORT)) chk_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .irq);
`default_nettype wire

/* sim/rmstat_traffic.sv */
/* Traffic side model: one-cycle frame, collision and drop reports.
   Called by the bench on clk; idle fields show inverted junk. */
`timescale 1ns/1ps
`default_nettype none
module rmstat_traffic
    import rmstat_pkg::*;
#(
    parameter int PW = 3
) (
    // Clock
    input  wire logic             clk,
    // Reports
    output logic                  frm_valid,
    output logic [PW-1:0]         frm_port,
    output logic [LEN_W-1:0]      frm_len,
    output logic                  frm_crc_ok,
    output logic                  frm_bcast,
    output logic                  frm_mcast,
    output logic                  coll_valid,
    output logic [PW-1:0]         coll_port,
    output logic                  drop_valid,
    output logic [PW-1:0]         drop_port
);
    initial {frm_valid, frm_port, frm_len, frm_crc_ok, frm_bcast, frm_mcast} = '0;
    initial {coll_valid, coll_port, drop_valid, drop_port} = '0;
    // Length counts check sequence, no preamble; reports spaced apart
    task automatic frame(input logic [PW-1:0] p, input logic [LEN_W-1:0] n, input logic [2:0] f);
        @(posedge clk);
        {frm_valid, frm_port, frm_len, frm_crc_ok, frm_bcast, frm_mcast} <= {1'b1, p, n, f};
        @(posedge clk);
        {frm_valid, frm_port, frm_len, frm_crc_ok, frm_bcast, frm_mcast} <= {1'b0, ~p, ~n, ~f};
        repeat (44) @(posedge clk);
    endtask
    task automatic ev(input logic is_drop, input logic [PW-1:0] p);
        @(posedge clk);
        {coll_valid, coll_port, drop_valid, drop_port} <= {!is_drop, p, is_drop, p};
        @(posedge clk);
        {coll_valid, coll_port, drop_valid, drop_port} <= {1'b0, ~p, 1'b0, ~p};
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/tb_rmon_frame_statistics.sv */
/* Bench for rmstat_top: APB master, traffic model, expected counters.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_rmon_frame_statistics
    import rmstat_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [PAW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] oper = '0;
    logic pready, pslverr, irq, fv, fok, fbc, fmc, cv, dv;
    logic [2:0] fp, cp, dp;
    logic [15:0] fl;
    logic [31:0] ex [NCNT];
    int error_cnt = 0, n_checks = 0;
    rmstat_top dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .frm_valid(fv), .frm_port(fp), .frm_len(fl), .frm_crc_ok(fok), .frm_bcast(fbc), .frm_mcast(fmc),
        .coll_valid(cv), .coll_port(cp), .drop_valid(dv), .drop_port(dp), .port_oper_valid(oper), .irq);
    rmstat_traffic tr_u (.clk, .frm_valid(fv), .frm_port(fp), .frm_len(fl), .frm_crc_ok(fok),
        .frm_bcast(fbc), .frm_mcast(fmc), .coll_valid(cv), .coll_port(cp), .drop_valid(dv), .drop_port(dp));
    always #20 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Expected counters of one frame
    task automatic add(input logic [15:0] n, input logic [2:0] f);
        ex[C_PKTS]++;
        ex[C_OCTETS] += {16'h0, n};
        if (f == 3'b110 || f == 3'b111) ex[C_BCAST]++;
        if (f == 3'b101) ex[C_MCAST]++;
        if (!f[2]) ex[C_CRC]++;
        if (n < 16'h0040) ex[f[2] ? C_UNDER : C_FRAG]++;
        if (n > 16'h05EE) ex[f[2] ? C_OVER : C_JAB]++;
        if (n == 16'h0040) ex[C_B64]++;
        if (n inside {[16'h0041:16'h007F]}) ex[C_B127]++;
        if (n inside {[16'h0080:16'h00FF]}) ex[C_B255]++;
        if (n inside {[16'h0100:16'h01FF]}) ex[C_B511]++;
        if (n inside {[16'h0200:16'h03FF]}) ex[C_B1023]++;
        if (n inside {[16'h0400:16'h05EE]}) ex[C_B1518]++;
    endtask
    task automatic cmp_all;
        for (int k = 0; k < NCNT; k++) begin
            apb(1'b0, REG_CNT_BASE + 12'(4 * k), 32'h0);
            chk($sformatf("counter %0d", k), rd, ex[k]);
        end
    endtask
    task automatic t_init;
        apb(1'b0, REG_CTRL, 32'h0);
        chk("init busy", rd & 32'h2, 32'h2);
        for (int k = 0; k < 200 && rd !== 32'h0; k++) apb(1'b0, REG_CTRL, 32'h0);
        apb(1'b0, REG_IRQ_ST, 32'h0);
        chk("irq status", rd, 32'h4);
        apb(1'b1, REG_IRQ_EN, 32'h4);
        repeat (3) @(posedge clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, REG_IRQ_EN, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, REG_IRQ_EN, 32'h4);
        apb(1'b1, REG_IRQ_CLR, 32'h4);
        repeat (3) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b1, REG_CNT_BASE, 32'h5);
        chk("counter write", {31'h0, err}, 32'h1);
        $display("init test done");
    endtask
    task automatic t_sel;
        apb(1'b1, REG_SEL, 32'h2);
        apb(1'b0, REG_SEL, 32'h0);
        chk("staged wrap", rd, 32'h7);
        for (int k = 0; k < 3; k++) apb(1'b1, REG_SEL, 32'h1);
        apb(1'b0, REG_SRC, 32'h0);
        chk("source before commit", rd, 32'h1);
        apb(1'b1, REG_SEL, 32'h4);
        apb(1'b0, REG_SRC, 32'h0);
        chk("source after commit", rd, 32'h3);
        oper <= 8'h04;
        apb(1'b0, REG_STAT, 32'h0);
        chk("status valid", rd, 32'h1);
        oper <= 8'hFB;
        apb(1'b0, REG_STAT, 32'h0);
        chk("status invalid", rd, 32'h0);
        $display("select test done");
    endtask
    task automatic t_frames;
        logic [15:0] ln [14] = '{16'h0040, 16'h003F, 16'h003F, 16'h05EF, 16'h05EF, 16'h0041, 16'h007F,
            16'h0080, 16'h00FF, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE};
        logic [2:0] fg [14] = '{3'b110, 3'b101, 3'b011, 3'b100, 3'b000, 3'b100, 3'b101,
            3'b000, 3'b111, 3'b100, 3'b010, 3'b100, 3'b101, 3'b001};
        for (int k = 0; k < 14; k++) begin
            tr_u.frame(3'h2, ln[k], fg[k]);
            add(ln[k], fg[k]);
        end
        tr_u.frame(3'h5, 16'h0100, 3'b100);
        for (int k = 0; k < 5; k++) tr_u.ev(k > 2, 3'h2);
        tr_u.ev(1'b0, 3'h5);
        {ex[C_COLL], ex[C_DROP]} = {32'h3, 32'h2};
        repeat (50) @(posedge clk);
        cmp_all;
        $display("frame test done");
    endtask
    task automatic t_clear;
        fork
            apb(1'b1, REG_CTRL, 32'h1);
            begin
                repeat (2) @(posedge clk);
                tr_u.frame(3'h2, 16'h0040, 3'b110);
            end
        join_any
        apb(1'b0, REG_CTRL, 32'h0);
        chk("clear busy", rd, 32'h1);
        for (int k = 0; k < 50 && rd !== 32'h0; k++) apb(1'b0, REG_CTRL, 32'h0);
        foreach (ex[k]) ex[k] = 32'h0;
        cmp_all;
        for (int k = 0; k < 3; k++) apb(1'b1, REG_SEL, 32'h1);
        apb(1'b1, REG_SEL, 32'h4);
        apb(1'b0, REG_CNT_BASE + 12'h024, 32'h0);
        chk("other port frames", rd, 32'h1);
        apb(1'b0, REG_CNT_BASE + 12'h004, 32'h0);
        chk("other port collisions", rd, 32'h1);
        $display("clear test done");
    endtask
    initial begin
        foreach (ex[k]) ex[k] = 32'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_init;
        t_sel;
        t_frames;
        t_clear;
        finish_test;
    end
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
